// >>> pkg/vfcm_params.svh
/*
  Constants for the two-lane float convert / multiply / divide datapath.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef VFCM_PARAMS_SVH
`define VFCM_PARAMS_SVH
// ==========================================================
// Opcode field (instruction bits 21..31)
`define VFCM_OPC_CVT_UINT 11'h294
`define VFCM_OPC_CVT_SINT 11'h295
`define VFCM_OPC_CVT_UFRAC 11'h296
`define VFCM_OPC_CVT_SFRAC 11'h297
`define VFCM_OPC_CVT_UINT_RZ 11'h298
`define VFCM_OPC_CVT_SINT_RZ 11'h29A
`define VFCM_OPC_MUL 11'h288
`define VFCM_OPC_DIV 11'h289
// ==========================================================
// Rounding mode codes
`define VFCM_RND_NEAR 2'h0
`define VFCM_RND_ZERO 2'h1
`define VFCM_RND_POS 2'h2
`define VFCM_RND_NEG 2'h3
// ==========================================================
// Number format
`define VFCM_EXP_ALL1 8'hFF
`define VFCM_BIAS 11'sh07F
`define VFCM_EXP_OVF 11'sh0FF
`define VFCM_FP_MAG_MAX 31'h7F7FFFFF
`define VFCM_CVT_OFS 10'sh096
`define VFCM_SFRAC_SCALE 10'sh01F
`define VFCM_UFRAC_SCALE 10'sh020
`define VFCM_CVT_SHIFT_LIM 10'sh029
`define VFCM_SINT_POS_MAX 32'h7FFFFFFF
`define VFCM_SINT_NEG_MAX 32'h80000000
`define VFCM_UINT_MAX 32'hFFFFFFFF
`endif

// >>> pkg/vfcm_pkg.sv
/*
  Types shared by the float datapath top and its lane unit.
  Assumes vfcm_params.svh sits on the include path.
*/
`default_nettype none
package vfcm_pkg;
  // ==========================================================
  // Operation class
  typedef enum logic [1:0] {VFCM_OP_NONE, VFCM_OP_CVT, VFCM_OP_DIV,
                            VFCM_OP_MUL} vfcm_op_t;
  // Issue request from the core
  typedef struct packed {
    logic valid;
    logic [10:0] opcode;
    logic [63:0] first_source_operand;
    logic [63:0] second_source_operand;
  } vfcm_req_t;
  // Exception enables
  typedef struct packed {
    logic invalid_exc_enable;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic inexact;
  } vfcm_exc_en_t;
  // Status bits toward the status/control register
  typedef struct packed {
    logic invalid_flag_hi;
    logic div_zero_flag_hi;
    logic overflow_flag_hi;
    logic underflow_flag_hi;
    logic guard_bit_hi;
    logic sticky_bit_hi;
    logic invalid_flag_lo;
    logic div_zero_flag_lo;
    logic overflow_flag_lo;
    logic underflow_flag_lo;
    logic guard_bit_lo;
    logic sticky_bit_lo;
    logic inexact_sticky_flag;
  } vfcm_fscr_t;
  // Interrupt requests, one-cycle pulses
  typedef struct packed {
    logic invalid;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic round;
  } vfcm_irq_t;
  // One lane's answer
  typedef struct packed {
    logic [31:0] result;
    logic [31:0] trunc;
    logic invalid;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic guard;
    logic sticky;
    logic inexact;
  } vfcm_lane_res_t;
  // Whole state of the top module
  typedef struct packed {
    logic [63:0] result;
    logic write;
    logic done;
    vfcm_fscr_t fscr;
    vfcm_irq_t irq;
  } vfcm_state_t;
endpackage
`default_nettype wire

// >>> rtl/vfcm_lane.sv
/*
  One 32-bit lane: float to integer/fraction conversion, multiply, divide.
  Purely combinational; the top registers its answer. Denormals are
  always flushed to zero.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vfcm_params.svh"
module vfcm_lane
  import vfcm_pkg::*;
(
  input wire vfcm_op_t op,
  input wire logic cvt_signed,
  input wire logic cvt_frac,
  input wire logic cvt_trunc,
  input wire logic [1:0] round_mode,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output vfcm_lane_res_t res
);
  // ==========================================================
  // Operand classification
  logic sa, sb, sr, a_zero, b_zero, a_den, b_den, a_spec, b_spec;
  logic [23:0] ma, mb;
  assign sa = op_a[31];
  assign sb = op_b[31];
  assign sr = sa ^ sb;
  assign a_zero = (op_a[30:0] == 31'h0);
  assign b_zero = (op_b[30:0] == 31'h0);
  assign a_den = (op_a[30:23] == 8'h0) && !a_zero;
  assign b_den = (op_b[30:23] == 8'h0) && !b_zero;
  assign a_spec = (op_a[30:23] == `VFCM_EXP_ALL1);
  assign b_spec = (op_b[30:23] == `VFCM_EXP_ALL1);
  assign ma = {1'b1, op_a[22:0]};
  assign mb = {1'b1, op_b[22:0]};

  // Rounding increment for the given mode
  function automatic logic rnd_inc(input logic [1:0] m, input logic sgn,
                                   input logic lsb, input logic g,
                                   input logic s);
    case (m)
      `VFCM_RND_NEAR: rnd_inc = g & (s | lsb);
      `VFCM_RND_POS: rnd_inc = !sgn & (g | s);
      `VFCM_RND_NEG: rnd_inc = sgn & (g | s);
      default: rnd_inc = 1'b0;
    endcase
  endfunction

  logic signed [9:0] amt;
  logic [9:0] nsh;
  logic [95:0] base, wide;
  logic [63:0] ipart;
  logic [64:0] mag;
  logic [47:0] prod;
  logic [49:0] quo, rem;
  logic [24:0] rm;
  logic [23:0] nm;
  logic [31:0] lim, rnd_val, trn_val;
  logic signed [10:0] ex;
  logic g, s, big, over;
  // ==========================================================
  // Lane datapath
  always_comb begin
    res = '0;
    // Defaults keep the arithmetic temporaries free of latches
    ex = '0;
    nm = '0;
    rm = '0;
    trn_val = '0;
    rnd_val = '0;
    amt = 10'(signed'({2'b00, op_b[30:23]})) - `VFCM_CVT_OFS +
          (cvt_frac ? (cvt_signed ? `VFCM_SFRAC_SCALE : `VFCM_UFRAC_SCALE)
                    : 10'sh000);
    nsh = 10'(-amt);
    base = {40'h0, mb, 32'h0};
    big = (amt >= `VFCM_CVT_SHIFT_LIM);
    wide = (amt >= 10'sh000) ? (base << amt[5:0]) : (base >> nsh);
    ipart = wide[95:32];
    g = wide[31];
    s = (|wide[30:0]) | ((amt < 10'sh000) &&
        |(base & ~({96{1'b1}} << nsh)));
    // NaN, zero and denormal convert as zero
    if (b_zero || b_den || (b_spec && op_b[22:0] != 23'h0)) begin
      ipart = 64'h0;
      g = 1'b0;
      s = 1'b0;
      big = 1'b0;
    end
    // Truncating forms ignore the selected mode
    mag = {1'b0, ipart} + 65'(rnd_inc(cvt_trunc ? `VFCM_RND_ZERO :
                                      round_mode, sb, ipart[0], g, s));
    if (cvt_signed) lim = sb ? `VFCM_SINT_NEG_MAX : `VFCM_SINT_POS_MAX;
    else lim = sb ? 32'h0 : `VFCM_UINT_MAX;
    over = big || (b_spec && op_b[22:0] == 23'h0) ||
           ((!cvt_signed && sb) ? (mag != 65'h0) : (mag > 65'(lim)));
    prod = ma * mb;
    quo = {ma, 26'h0} / {26'h0, mb};
    rem = {ma, 26'h0} % {26'h0, mb};
    if (op == VFCM_OP_CVT) begin
      // Saturate anything out of range
      if (over) res.result = lim;
      else if (cvt_signed && sb) res.result = 32'(-mag);
      else res.result = mag[31:0];
      res.invalid = b_spec || b_den || over;
      res.guard = !res.invalid & g;
      res.sticky = !res.invalid & s;
      res.inexact = res.guard | res.sticky;
    end else if (op != VFCM_OP_NONE) begin
      if (op == VFCM_OP_MUL) begin
        ex = 11'(op_a[30:23]) + 11'(op_b[30:23]) - `VFCM_BIAS;
        if (prod[47]) begin
          nm = prod[47:24];
          g = prod[23];
          s = |prod[22:0];
          ex = ex + 11'sh001;
        end else begin
          nm = prod[46:23];
          g = prod[22];
          s = |prod[21:0];
        end
      end else begin
        ex = 11'(op_a[30:23]) - 11'(op_b[30:23]) + `VFCM_BIAS;
        if (quo[26]) begin
          nm = quo[26:3];
          g = quo[2];
          s = (|quo[1:0]) | (rem != 50'h0);
        end else begin
          nm = quo[25:2];
          g = quo[1];
          s = quo[0] | (rem != 50'h0);
          ex = ex - 11'sh001;
        end
      end
      trn_val = {sr, ex[7:0], nm[22:0]};
      rm = {1'b0, nm} + 25'(rnd_inc(round_mode, sr, nm[0], g, s));
      if (rm[24]) begin
        rm = rm >> 1;
        ex = ex + 11'sh001;
      end
      rnd_val = {sr, ex[7:0], rm[22:0]};
      res.overflow = (ex >= `VFCM_EXP_OVF);
      res.underflow = (ex <= 11'sh000);
      // Saturate to max or signed zero
      if (res.overflow) begin
        rnd_val = {sr, `VFCM_FP_MAG_MAX};
        trn_val = rnd_val;
      end else if (res.underflow) begin
        rnd_val = {sr, 31'h0};
        trn_val = rnd_val;
      end
      res.guard = g;
      res.sticky = s;
      res.inexact = g | s;
      res.result = rnd_val;
      res.trunc = trn_val;
      res.invalid = a_spec || b_spec || a_den || b_den ||
                    (op == VFCM_OP_DIV && a_zero && b_zero);
      res.div_zero = (op == VFCM_OP_DIV) && !res.invalid && b_zero &&
                     !a_zero;
      // Special operands override the computed value
      if ((op == VFCM_OP_DIV && b_spec) ||
          (op == VFCM_OP_MUL && (a_zero || b_zero || a_den || b_den)) ||
          (op == VFCM_OP_DIV && !(b_zero || b_den || a_spec) &&
           (a_zero || a_den))) begin
        res.result = {sr, 31'h0};
        res.trunc = res.result;
        res = '{result: res.result, trunc: res.trunc, invalid: res.invalid,
                div_zero: res.div_zero, default: 1'b0};
      end else if (b_zero || b_den || a_spec || b_spec) begin
        res.result = {sr, `VFCM_FP_MAG_MAX};
        res.trunc = res.result;
        res = '{result: res.result, trunc: res.trunc, invalid: res.invalid,
                div_zero: res.div_zero, default: 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/vfcm_top.sv
/*
  Two-lane single-precision convert / multiply / divide unit.
  Assumes requests come from the core issue stage in the sys_clk domain;
  the answer appears one enabled clock after the request.
*/
// Notes on behaviour
// - Signed truncating conversion saturates to 32 bits
// - NaN lanes convert as if zero
// - Unsigned fraction uses current mode, saturates
// - Unsigned integer uses current mode, saturates
// - Unsigned truncating conversion rounds toward zero, saturates
// - Special input or overflow: invalid, clear guard/sticky
// - Enabled invalid: interrupt, no write, nothing else
// - Divide by NaN or infinity gives signed zero
// - Divide by zero or special dividend: signed max
// - Overflow gives signed max, underflow signed zero
// - Divide invalid on specials or zero over zero
// - Enabled invalid in arithmetic: interrupt, no write
// - Zero divisor, normal dividend: divide-by-zero flag
// - Otherwise flag overflow and underflow per lane
// - Enabled overflow/underflow: interrupt, no write
// - Inexact or masked range error sets sticky inexact
// - Enabled inexact in arithmetic: round interrupt, write truncated
// - Guard/sticky cleared on range interrupt or invalid
// - Multiply by zero or denormal gives signed zero
// - Multiply with NaN or infinity gives signed max, unless the other operand is zero or denormal
`timescale 1ns/1ps
`default_nettype none
`include "vfcm_params.svh"
module vfcm_top
  import vfcm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire vfcm_req_t req,
  input wire logic [1:0] round_mode,
  input wire vfcm_exc_en_t exc_en,
  input wire logic inexact_clear,
  output logic [63:0] dest_result,
  output logic dest_write,
  output logic op_done,
  output vfcm_fscr_t float_status_control_reg,
  output vfcm_irq_t exc_irq
);
  // ==========================================================
  // Opcode decode
  vfcm_op_t op; // Operation class
  logic cvt_signed; // Signed destination
  logic cvt_frac; // Fraction destination
  logic cvt_trunc; // Forced round toward zero

  // Address-style decode of the opcode field
  always_comb begin
    op = VFCM_OP_CVT;
    cvt_signed = 1'b0;
    cvt_frac = 1'b0;
    cvt_trunc = 1'b0;
    if (req.opcode == `VFCM_OPC_CVT_SINT_RZ) begin
      cvt_signed = 1'b1;
      cvt_trunc = 1'b1;
    end else if (req.opcode == `VFCM_OPC_CVT_SINT) begin
      cvt_signed = 1'b1;
    end else if (req.opcode == `VFCM_OPC_CVT_SFRAC) begin
      cvt_signed = 1'b1;
      cvt_frac = 1'b1;
    end else if (req.opcode == `VFCM_OPC_CVT_UFRAC) begin
      cvt_frac = 1'b1;
    end else if (req.opcode == `VFCM_OPC_CVT_UINT) begin
      cvt_trunc = 1'b0;
    end else if (req.opcode == `VFCM_OPC_CVT_UINT_RZ) begin
      cvt_trunc = 1'b1;
    end else if (req.opcode == `VFCM_OPC_DIV) begin
      op = VFCM_OP_DIV;
    end else if (req.opcode == `VFCM_OPC_MUL) begin
      op = VFCM_OP_MUL;
    end else begin
      op = VFCM_OP_NONE; // Foreign opcode, not ours
    end
  end

  // ==========================================================
  // Lane units, upper word and lower word
  vfcm_lane_res_t hi; // Upper lane answer
  vfcm_lane_res_t lo; // Lower lane answer

  vfcm_lane u_lane_hi (
    .op(op),
    .cvt_signed(cvt_signed),
    .cvt_frac(cvt_frac),
    .cvt_trunc(cvt_trunc),
    .round_mode(round_mode),
    .op_a(req.first_source_operand[63:32]),
    .op_b(req.second_source_operand[63:32]),
    .res(hi)
  );

  vfcm_lane u_lane_lo (
    .op(op),
    .cvt_signed(cvt_signed),
    .cvt_frac(cvt_frac),
    .cvt_trunc(cvt_trunc),
    .round_mode(round_mode),
    .op_a(req.first_source_operand[31:0]),
    .op_b(req.second_source_operand[31:0]),
    .res(lo)
  );

  // ==========================================================
  // State
  vfcm_state_t st_q; // Registered state
  vfcm_state_t st_d; // Next state
  logic inv_any; // Either lane invalid
  logic dbz_any; // Either lane divides by zero
  logic ovf_any; // Either lane overflows
  logic unf_any; // Either lane underflows
  logic range_irq; // Range interrupt is taken
  logic inx_any; // Inexact result worth flagging

  assign inv_any = hi.invalid | lo.invalid;
  assign dbz_any = hi.div_zero | lo.div_zero;
  assign ovf_any = hi.overflow | lo.overflow;
  assign unf_any = hi.underflow | lo.underflow;
  assign range_irq = (ovf_any & exc_en.overflow) |
                     (unf_any & exc_en.underflow);
  // Masked range errors count as inexact too
  assign inx_any = hi.inexact | lo.inexact | ovf_any | unf_any;

  // Next-state logic: one answer per accepted request
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.write = 1'b0;
    st_d.irq = '0;
    // Software clear first so a new inexact event still wins
    if (inexact_clear) begin
      st_d.fscr.inexact_sticky_flag = 1'b0;
    end
    if (req.valid && op != VFCM_OP_NONE) begin
      st_d.done = 1'b1;
      // Per-operation flags start clean; guard/sticky cleared
      st_d.fscr = '0;
      st_d.fscr.inexact_sticky_flag = st_q.fscr.inexact_sticky_flag &
                                      !inexact_clear;
      st_d.fscr.invalid_flag_hi = hi.invalid;
      st_d.fscr.invalid_flag_lo = lo.invalid;
      if (inv_any && exc_en.invalid_exc_enable) begin
        // Trap: no write and no other status
        st_d.irq.invalid = 1'b1;
      end else if (op == VFCM_OP_CVT) begin
        // Conversion result goes out, lanes independent
        st_d.write = 1'b1;
        st_d.result = {hi.result, lo.result};
        st_d.fscr.guard_bit_hi = hi.guard;
        st_d.fscr.sticky_bit_hi = hi.sticky;
        st_d.fscr.guard_bit_lo = lo.guard;
        st_d.fscr.sticky_bit_lo = lo.sticky;
        if (hi.inexact || lo.inexact) begin
          st_d.fscr.inexact_sticky_flag = 1'b1;
        end
      end else begin
        st_d.fscr.div_zero_flag_hi = hi.div_zero;
        st_d.fscr.div_zero_flag_lo = lo.div_zero;
        if (dbz_any && exc_en.div_zero) begin
          st_d.irq.div_zero = 1'b1;
        end else begin
          st_d.fscr.overflow_flag_hi = hi.overflow;
          st_d.fscr.overflow_flag_lo = lo.overflow;
          st_d.fscr.underflow_flag_hi = hi.underflow;
          st_d.fscr.underflow_flag_lo = lo.underflow;
          if (range_irq) begin
            // Destination kept, guard/sticky stay clear
            st_d.irq.overflow = ovf_any & exc_en.overflow;
            st_d.irq.underflow = unf_any & exc_en.underflow;
          end else begin
            st_d.write = 1'b1;
            st_d.fscr.guard_bit_hi = hi.guard;
            st_d.fscr.sticky_bit_hi = hi.sticky;
            st_d.fscr.guard_bit_lo = lo.guard;
            st_d.fscr.sticky_bit_lo = lo.sticky;
            if (inx_any) begin
              st_d.fscr.inexact_sticky_flag = 1'b1;
            end
            if (inx_any && exc_en.inexact) begin
              // Handler finishes rounding from guard/sticky
              st_d.irq.round = 1'b1;
              st_d.result = {hi.trunc, lo.trunc};
            end else begin
              st_d.result = {hi.result, lo.result};
            end
          end
        end
      end
    end
  end

  // Register the state; clock enable freezes everything
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign dest_result = st_q.result;
  assign dest_write = st_q.write;
  assign op_done = st_q.done;
  assign float_status_control_reg = st_q.fscr;
  assign exc_irq = st_q.irq;

  // ==========================================================
  // Checks
  // Positive out-of-range value saturates in truncating signed form
  chk_siz_saturate: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clk_en && req.valid && req.opcode == `VFCM_OPC_CVT_SINT_RZ &&
     !exc_en.invalid_exc_enable && !req.second_source_operand[31] &&
     req.second_source_operand[30:23] >= 8'h9E &&
     req.second_source_operand[30:23] != `VFCM_EXP_ALL1)
    |=> dest_write && dest_result[31:0] == `VFCM_SINT_POS_MAX &&
        float_status_control_reg.invalid_flag_lo)
    else $error("signed truncation did not saturate");

  // NaN lane converts as zero and flags invalid
  chk_nan_as_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clk_en && req.valid && op == VFCM_OP_CVT &&
     !exc_en.invalid_exc_enable &&
     req.second_source_operand[30:23] == `VFCM_EXP_ALL1 &&
     req.second_source_operand[22:0] != 23'h0)
    |=> dest_result[31:0] == 32'h0 &&
        float_status_control_reg.invalid_flag_lo &&
        !float_status_control_reg.guard_bit_lo)
    else $error("NaN lane not converted as zero");

  // Negative value to an unsigned form saturates at zero
  chk_uns_negative: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clk_en && req.valid && op == VFCM_OP_CVT && !cvt_signed &&
     !exc_en.invalid_exc_enable && req.second_source_operand[63])
    |=> dest_write && dest_result[63:32] == 32'h0)
    else $error("negative unsigned result not zero");

  // Enabled invalid trap blocks the write and the round and divide-by-zero traps
  chk_inv_blocks: assert property (
    @(posedge sys_clk) disable iff (rst)
    exc_irq.invalid |-> !dest_write && !exc_irq.round &&
    !exc_irq.div_zero && op_done &&
    !float_status_control_reg.overflow_flag_lo)
    else $error("invalid trap wrote or raised others");

  // Divisor infinity with divide gives signed zero when written
  chk_div_by_inf: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clk_en && req.valid && op == VFCM_OP_DIV &&
     req.second_source_operand[30:23] == `VFCM_EXP_ALL1)
    |=> !dest_write || (dest_result[30:0] == 31'h0 &&
        dest_result[31] == $past(req.first_source_operand[31] ^
                                 req.second_source_operand[31])))
    else $error("divide by infinity not signed zero");

  // Zero divisor with normal dividend raises divide-by-zero
  chk_dbz_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clk_en && req.valid && op == VFCM_OP_DIV &&
     !exc_en.invalid_exc_enable &&
     req.second_source_operand[30:0] == 31'h0 &&
     req.first_source_operand[30:23] != 8'h0 &&
     req.first_source_operand[30:23] != `VFCM_EXP_ALL1)
    |=> float_status_control_reg.div_zero_flag_lo &&
        exc_irq.div_zero == $past(exc_en.div_zero))
    else $error("divide-by-zero not flagged");

  // Range trap leaves destination alone and guard bits cleared
  chk_range_trap: assert property (
    @(posedge sys_clk) disable iff (rst)
    (exc_irq.overflow || exc_irq.underflow) |-> !dest_write &&
    !float_status_control_reg.guard_bit_lo &&
    !float_status_control_reg.sticky_bit_hi)
    else $error("range trap wrote or kept guard bits");

  // Round trap writes a result and leaves sticky inexact set
  chk_round_trap: assert property (
    @(posedge sys_clk) disable iff (rst)
    exc_irq.round |-> dest_write &&
    float_status_control_reg.inexact_sticky_flag ##1
    (float_status_control_reg.inexact_sticky_flag || $past(inexact_clear)))
    else $error("round trap without write or sticky");
endmodule
`default_nettype wire

// >>> tb/vfcm_core_model.sv
/*
  Issue-stage model of the core that feeds the float datapath.
  Assumes the bench drives issue/opcode/operands just after sys_clk rises.
*/
`timescale 1ns/1ps
`default_nettype none
module vfcm_core_model
  import vfcm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic issue,
  input wire logic [10:0] opcode,
  input wire logic [63:0] src_a,
  input wire logic [63:0] src_b,
  output vfcm_req_t req
);
  // ==========================================================
  // Issue register; released operands show inverted stale data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req <= '0;
    end else if (issue) begin
      req <= '{1'b1, opcode, src_a, src_b};
    end else begin
      req <= '{1'b0, req.opcode, ~req.first_source_operand,
               ~req.second_source_operand};
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the two-lane convert / multiply / divide unit.
  Assumes the core model above and the design package on the path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vfcm_params.svh"
module tb;
  import vfcm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic go = 1'b0;
  logic [10:0] opc = 11'h000;
  logic [63:0] opa = 64'h0;
  logic [63:0] opb = 64'h0;
  logic [1:0] round_mode = 2'h0;
  vfcm_exc_en_t exc_en = '0;
  logic inexact_clear = 1'b0;
  vfcm_req_t req;
  logic [63:0] dres;
  logic dwr;
  logic done;
  vfcm_fscr_t fs;
  vfcm_irq_t irq;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // ==========================================================
  // Clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  vfcm_core_model core (.sys_clk(sys_clk), .rst(rst), .issue(go),
    .opcode(opc), .src_a(opa), .src_b(opb), .req(req));
  vfcm_top dut (.sys_clk(sys_clk), .rst(rst), .clk_en(ce), .req(req),
    .round_mode(round_mode), .exc_en(exc_en),
    .inexact_clear(inexact_clear), .dest_result(dres), .dest_write(dwr),
    .op_done(done), .float_status_control_reg(fs), .exc_irq(irq));
  // Exact float bits of a small integer (magnitude below 2**24)
  function automatic logic [31:0] f32(input int v);
    int m;
    int e;
    m = (v < 0) ? -v : v;
    e = 0;
    if (m == 0) return 32'h0;
    while ((m >> e) > 1) e++;
    return {v < 0, 8'(127 + e), 23'((m << (23 - e)) & 32'h7FFFFF)};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Issue one request; outputs are settled when this returns
  task automatic run(input logic [10:0] o, input logic [63:0] a,
                     input logic [63:0] b, input vfcm_exc_en_t en);
    @(posedge sys_clk);
    go <= 1'b1;
    opc <= o;
    opa <= a;
    opb <= b;
    exc_en <= en;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(41));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    run(`VFCM_OPC_CVT_SINT_RZ, 0, {32'h40700000, 32'hC0200000}, 5'h00);
    chk("sint_rz", 64'h00000003FFFFFFFE, dres);
    chk("op_done", 64'h1, {63'h0, done});
    run(`VFCM_OPC_CVT_SINT, 0, {32'h40200000, 32'hC0BCCCCD}, 5'h00);
    chk("sint_rn", 64'h00000002FFFFFFFA, dres);
    run(`VFCM_OPC_CVT_SFRAC, 0, {32'h3F000000, 32'hBE800000}, 5'h00);
    chk("sfrac", 64'h40000000E0000000, dres);
    run(`VFCM_OPC_CVT_SINT_RZ, 0, {32'h7FC00000, 32'h4F32D05E}, 5'h00);
    chk("nan_sat", 64'h000000007FFFFFFF, dres);
    chk("cvt_inv", 2'h3, {fs.invalid_flag_hi, fs.invalid_flag_lo});
    chk("cvt_gs", 4'h0, {fs.guard_bit_hi, fs.sticky_bit_hi, fs.guard_bit_lo,
        fs.sticky_bit_lo});
    run(`VFCM_OPC_CVT_UINT, 0, {32'h40200000, 32'h40BCCCCD}, 5'h00);
    chk("uint_rn", 64'h0000000200000006, dres);
    round_mode <= `VFCM_RND_POS;
    run(`VFCM_OPC_CVT_UINT, 0, {32'h40200000, 32'h40BCCCCD}, 5'h00);
    chk("uint_rp", 64'h0000000300000006, dres);
    round_mode <= `VFCM_RND_NEG;
    run(`VFCM_OPC_CVT_UINT, 0, {32'h40200000, 32'h40BCCCCD}, 5'h00);
    chk("uint_rm", 64'h0000000200000005, dres);
    round_mode <= `VFCM_RND_NEAR;
    run(`VFCM_OPC_CVT_UINT_RZ, 0, {32'h40200000, 32'h40BCCCCD}, 5'h00);
    chk("uint_rz", 64'h0000000200000005, dres);
    run(`VFCM_OPC_CVT_UFRAC, 0, {32'h3F000000, 32'h3E800000}, 5'h00);
    chk("ufrac", 64'h8000000040000000, dres);
    run(`VFCM_OPC_CVT_SINT_RZ, 0, {32'h7F800000, 32'h3F800000}, 5'h10);
    chk("cvt_trap", 7'h21, {dwr, irq, 1'b1});
    chk("cvt_keep", 64'h8000000040000000, dres);
    run(`VFCM_OPC_MUL, {32'h40000000, 32'hC0000000},
        {32'h40400000, 32'h00000000}, 5'h00);
    chk("mul_zero", 64'h40C0000080000000, dres);
    ce <= 1'b0;
    run(`VFCM_OPC_MUL, {2{32'h3F800000}}, {2{32'h40000000}}, 5'h00);
    chk("ce_hold", 64'h40C0000080000000, dres);
    ce <= 1'b1;
    run(`VFCM_OPC_MUL, {32'h7F800000, 32'h3F800000},
        {32'h40000000, 32'hBF800000}, 5'h00);
    chk("mul_inf", 64'h7F7FFFFFBF800000, dres);
    run(`VFCM_OPC_MUL, {2{32'h7F000000}}, {32'h7F000000, 32'h3F800000}, 5'h0);
    chk("mul_ovf", 64'h7F7FFFFF7F000000, dres);
    chk("ovf_flg", 3'h5, {fs.overflow_flag_hi, fs.overflow_flag_lo,
        fs.inexact_sticky_flag});
    inexact_clear <= 1'b1;
    @(posedge sys_clk);
    inexact_clear <= 1'b0;
    run(`VFCM_OPC_MUL, {2{32'h7F000000}}, {32'h7F000000, 32'h3F800000}, 5'h4);
    chk("ovf_trap", 6'h04, {dwr, irq});
    chk("ovf_gs", 3'h0, {fs.guard_bit_hi, fs.sticky_bit_hi,
        fs.inexact_sticky_flag});
    run(`VFCM_OPC_MUL, {2{32'h3F800001}}, {2{32'h3F800001}}, 5'h01);
    chk("rnd_trap", 64'h3F8000023F800002, dres);
    chk("rnd_irq", 6'h21, {dwr, irq});
    run(`VFCM_OPC_DIV, {32'h40C00000, 32'h3F800000},
        {32'h40000000, 32'hFF800000}, 5'h00);
    chk("div_inf", 64'h4040000080000000, dres);
    run(`VFCM_OPC_DIV, {32'h3F800000, 32'hC0000000}, 64'h0, 5'h00);
    chk("div_zero", 64'h7F7FFFFFFF7FFFFF, dres);
    chk("dbz_flg", 2'h3, {fs.div_zero_flag_hi, fs.div_zero_flag_lo});
    run(`VFCM_OPC_DIV, {32'h3F800000, 32'hC0000000}, 64'h0, 5'h08);
    chk("dbz_trap", 6'h08, {dwr, irq});
    run(`VFCM_OPC_DIV, {32'h0, 32'h3F800000}, {32'h0, 32'h3F800000}, 5'h10);
    chk("div_inv", 8'h90, {fs.invalid_flag_hi, fs.invalid_flag_lo, dwr,
        irq});
    for (int i = 0; i < 20; i++) begin
      n = int'($urandom_range(2000)) - 1000;
      run(`VFCM_OPC_CVT_SINT_RZ, 0, {f32(n), f32(-n)}, 5'h00);
      chk("rand_cvt", {32'(n), 32'(-n)}, dres);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
